// >>> dv/flash_guard_assertions.sv
// concurrent checks on the flash guard top ports
// assumes it is bound into flash_guard; one clock domain, async reset pin
`timescale 1ns/1ps
`default_nettype none
module flash_guard_assertions (
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_cs_n,
    input wire logic       i_sclk,
    input wire logic       i_hold_n,
    input wire logic       o_serial_in_lane0_oe,
    input wire logic       o_serial_out_lane1_oe,
    input wire logic       o_operation_in_progress,
    input wire logic       o_write_enable_latch,
    input wire logic [1:0] o_protect_level,
    input wire logic       o_deep_sleep_mode,
    input wire logic       o_standby
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_busy_no_standby: assert property (
        o_operation_in_progress && $past(o_operation_in_progress)
        |-> !o_standby) else $error("standby shown while busy");
    a_select_active: assert property (
        !i_cs_n [*6] |-> !o_standby)
        else $error("standby shown while selected");
    a_busy_after_end: assert property (
        $rose(o_operation_in_progress) |-> i_cs_n && $past(i_cs_n, 2))
        else $error("busy started inside a frame");
    a_latch_clears: assert property (
        $fell(o_operation_in_progress) |-> ##[0:2] !o_write_enable_latch)
        else $error("latch kept after operation end");
    a_level_at_end: assert property (
        $changed(o_protect_level)
        |-> $past(o_operation_in_progress)
            || $past(o_operation_in_progress, 2))
        else $error("level changed outside a status write");
    a_sleep_blocks: assert property (
        o_deep_sleep_mode && $past(o_deep_sleep_mode)
        |-> !$rose(o_write_enable_latch))
        else $error("latch set during deep sleep");
    a_busy_blocks: assert property (
        o_operation_in_progress && $past(o_operation_in_progress)
        |-> !$rose(o_write_enable_latch))
        else $error("latch set while busy");
    a_pause_floats: assert property (
        (!i_hold_n && !i_sclk && !i_cs_n) [*6]
        |-> !o_serial_out_lane1_oe && !o_serial_in_lane0_oe)
        else $error("lane driven during pause");
    a_deselect_float: assert property (
        i_cs_n [*6] |-> !o_serial_out_lane1_oe && !o_serial_in_lane0_oe)
        else $error("lane driven while deselected");
endmodule
`default_nettype wire

// >>> dv/flash_guard_tb.sv
// self-checking bench for the flash guard, driven through the host model
// assumes the busy times are shortened through the top's parameters
`timescale 1ns/1ps
`default_nettype none
module flash_guard_tb;
    logic       clk;
    logic       rst_n;
    logic       wp_n;
    logic       cs_n;
    logic       sclk;
    logic       mosi;
    logic       hold_n;
    wire        lane0_w;
    wire        miso_w;
    wire        l0;
    wire        l0_oe;
    wire        l1;
    wire        l1_oe;
    wire        busy;
    wire        latch;
    wire        lock;
    wire        sleep;
    wire        stby;
    wire [1:0]  lvl;
    integer     failures = 0;
    integer     n_tests = 0;

    // the device wins lane0 only while it enables it
    assign lane0_w = l0_oe ? l0 : mosi;
    assign miso_w = l1_oe ? l1 : ~l1;

    flash_guard #(.PROG_CYC(10), .SECT_CYC(10), .BLK_CYC(10), .CE_CYC(10),
        .STW_CYC(10)) uut (
        .i_clock(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_serial_in_lane0(lane0_w), .i_hold_n(hold_n), .i_wp_n(wp_n),
        .o_serial_in_lane0(l0), .o_serial_in_lane0_oe(l0_oe),
        .o_serial_out_lane1(l1), .o_serial_out_lane1_oe(l1_oe),
        .o_operation_in_progress(busy), .o_write_enable_latch(latch),
        .o_protect_level(lvl), .o_status_lock_bit(lock),
        .o_deep_sleep_mode(sleep), .o_standby(stby));

    spi_host_model host (.i_clock(clk), .i_miso(miso_w), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_mosi(mosi), .o_hold_n(hold_n));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [7:0] st();
        return {lock, 3'h0, lvl, latch, busy};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic send(input logic [7:0] op, input logic [23:0] a,
                        input logic [7:0] d, input logic [1:0] fmt);
        host.frame_start();
        host.xfer(op, 8);
        if (fmt[1]) begin
            host.xfer(a[23:16], 8);
            host.xfer(a[15:8], 8);
            host.xfer(a[7:0], 8);
        end
        if (fmt[0])
            host.xfer(d, 8);
        host.frame_end();
    endtask

    task automatic wait_idle();
        integer k;
        for (k = 0; k < 9000 && busy !== 1'b0; k++)
            @(posedge clk);
        check({7'h0, busy}, 8'h00);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_latch();
        check({6'h0, sleep, stby}, 8'h01);
        check(st(), 8'h00);
        send(8'h06, 24'h0, 8'h0, 2'b00); // write enable first
        check(st(), 8'h02);
        send(8'h04, 24'h0, 8'h0, 2'b00);
        check(st(), 8'h00);
        host.frame_start();
        host.xfer(8'h06, 7);
        host.frame_end();
        check(st(), 8'h00);
    endtask

    task automatic t_guard();
        @(posedge clk);
        wp_n <= 1'b0;
        send(8'h06, 24'h0, 8'h0, 2'b00);
        send(8'h01, 24'h0, 8'h04, 2'b01);
        wait_idle();
        check({6'h0, lvl}, 8'h00);
        @(posedge clk);
        wp_n <= 1'b1;
        send(8'h04, 24'h0, 8'h0, 2'b00);
        send(8'h06, 24'h0, 8'h0, 2'b00);
        send(8'h01, 24'h0, 8'h04, 2'b01);
        check({7'h0, busy}, 8'h01);
        wait_idle();
        check(st(), 8'h04);
        host.frame_start();
        host.xfer(8'h05, 8);
        host.pause_on();
        check({6'h0, l1_oe, l0_oe}, 8'h00);
        host.pause_off();
        host.xfer(8'h00, 8);
        check(host.rx, 8'h04);
        host.frame_end();
    endtask

    task automatic t_array();
        send(8'h06, 24'h0, 8'h0, 2'b00);
        send(8'h20, 24'h010000, 8'h0, 2'b10);
        check({7'h0, busy}, 8'h00);
        send(8'h04, 24'h0, 8'h0, 2'b00);
        send(8'h02, 24'h000010, 8'ha5, 2'b11);
        check({7'h0, busy}, 8'h00);
        send(8'h06, 24'h0, 8'h0, 2'b00);
        send(8'h20, 24'h000000, 8'h0, 2'b10); // erase before program
        check({7'h0, busy}, 8'h01);
        wait_idle();
        check(st(), 8'h04);
        send(8'h06, 24'h0, 8'h0, 2'b00);
        send(8'h02, 24'h000010, 8'ha5, 2'b11);
        check({7'h0, busy}, 8'h01);
        wait_idle();
        host.frame_start();
        host.xfer(8'h03, 8);
        host.xfer(8'h00, 8);
        host.xfer(8'h00, 8);
        host.xfer(8'h10, 8);
        host.xfer(8'h00, 8);
        check(host.rx, 8'ha5);
        host.xfer(8'h00, 8);
        check(host.rx, 8'hff);
        host.frame_end();
        host.frame_start();
        host.xfer(8'h3b, 8);
        host.xfer(8'h00, 8);
        host.xfer(8'h00, 8);
        host.xfer(8'h10, 8);
        host.xfer(8'h00, 4);
        check({4'h0, host.rx[3:0]}, 8'h0c);
        check({6'h0, l0_oe, l0}, 8'h03);
        host.frame_end();
    endtask

    task automatic t_sleep();
        send(8'hb9, 24'h0, 8'h0, 2'b00);
        check({7'h0, sleep}, 8'h01);
        send(8'h06, 24'h0, 8'h0, 2'b00);
        check(st(), 8'h04);
        host.frame_start();
        host.xfer(8'hab, 8);
        repeat (4) host.xfer(8'h00, 8);
        check(host.rx, 8'h3c);
        host.frame_end();
        check({7'h0, sleep}, 8'h00);
    endtask

    initial begin
        rst_n = 1'b0;
        wp_n = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_latch();
        t_guard();
        t_array();
        t_sleep();
        end_of_test();
    end

    // whole run needs about 8000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule

bind flash_guard flash_guard_assertions chk (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .i_hold_n(i_hold_n),
    .o_serial_in_lane0_oe(o_serial_in_lane0_oe),
    .o_serial_out_lane1_oe(o_serial_out_lane1_oe),
    .o_operation_in_progress(o_operation_in_progress),
    .o_write_enable_latch(o_write_enable_latch),
    .o_protect_level(o_protect_level),
    .o_deep_sleep_mode(o_deep_sleep_mode), .o_standby(o_standby));
`default_nettype wire

// >>> dv/spi_host_model.sv
// serial host model: mode 0 frames, 320 ns serial clock
// assumes i_clock at 40 ns; one bit takes eight of its cycles
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic i_clock,
    input  wire logic i_miso,
    output var  logic o_cs_n,
    output var  logic o_sclk,
    output var  logic o_mosi,
    output var  logic o_hold_n
);
    logic [7:0] rx;

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0; // rests low outside frames
        o_mosi = 1'b0;
        o_hold_n = 1'b1;
        rx = 8'h00;
    end

    task automatic tick(input integer n);
        repeat (n) @(posedge i_clock);
    endtask

    task automatic frame_start();
        tick(1);
        o_cs_n <= 1'b0;
        tick(4);
    endtask

    // msb first; launched with the fall, taken by the device at the rise
    task automatic xfer(input logic [7:0] b, input integer n);
        integer i;
        for (i = 0; i < n; i++) begin
            o_sclk <= 1'b0;
            o_mosi <= b[7-i];
            tick(4);
            o_sclk <= 1'b1;
            tick(4);
            rx = {rx[6:0], i_miso};
        end
    endtask

    task automatic frame_end();
        o_sclk <= 1'b0;
        tick(4);
        o_cs_n <= 1'b1;
        o_mosi <= ~o_mosi; // released line must not echo the last bit
        tick(10);
    endtask

    // pause only begins and ends with the clock low
    task automatic pause_on();
        o_sclk <= 1'b0;
        tick(4);
        o_hold_n <= 1'b0;
        tick(8);
    endtask

    task automatic pause_off();
        o_hold_n <= 1'b1;
        tick(4);
    endtask
endmodule
`default_nettype wire

// >>> hw/flash_guard.v
// serial flash command front end with write protection and array model
// assumes pins arrive asynchronous; sclk well below a quarter of i_clock
// How it works
// - data sampled on sclk rise, driven on fall; idle level free.
// - 32 sectors of 4K, each erasable alone.
// - two 64K blocks, each erasable alone.
// - programs one 256-byte page from a buffer, self-timed.
// - page program busy for the 3 ms maximum.
// - erase wipes and completes on its own timer.
// - commands act only when bit count ends on a byte.
// - in-progress bit set during status write, program, erase.
// - standby when select high and nothing busy.
// - reset puts control in standby.
// - changes happen only at the end of a complete command.
// - data changing commands need the write enable latch.
// - latch clears at reset, disable and end of any change.
// - level 0 none, 1 upper block, 2 and 3 whole array.
// - protect pin low refuses status writes to level and lock.
// - deep sleep ignores all but wake and signature read.
// - dual read drives two bits per clock on both lanes.
// - reads run on across the whole array, wrapping.
// - signature read gives one byte; id read gives three.
// - pause does not stop internal busy operations.
// - while paused outputs float, clock and input ignored.
// - select high during pause resets link logic.
`timescale 1ns/1ps
`default_nettype none
`include "flash_guard_defines.vh"

module flash_guard #(
    parameter       ADDR_W   = `ADDR_W,
    parameter [7:0] MFR_ID   = 8'h5a,   // arbitrary value
    parameter [15:0] DEV_ID  = 16'h2b11, // arbitrary value
    parameter [7:0] SIG_ID   = 8'h3c,   // arbitrary value
    parameter       PROG_CYC = `PROG_CYC,
    parameter       SECT_CYC = `SECT_CYC,
    parameter       BLK_CYC  = `BLK_CYC,
    parameter       CE_CYC   = `CE_CYC,
    parameter       STW_CYC  = `STW_CYC
) (
    input  wire       i_clock,
    input  wire       i_rst_n,
    input  wire       i_cs_n,
    input  wire       i_sclk,
    input  wire       i_serial_in_lane0,
    input  wire       i_hold_n,
    input  wire       i_wp_n,
    output reg        o_serial_in_lane0,
    output reg        o_serial_in_lane0_oe,
    output reg        o_serial_out_lane1,
    output reg        o_serial_out_lane1_oe,
    output reg        o_operation_in_progress,
    output reg        o_write_enable_latch,
    output reg  [1:0] o_protect_level,
    output reg        o_status_lock_bit,
    output reg        o_deep_sleep_mode,
    output reg        o_standby
);
    localparam [1:0] K_STATUS = 2'h0;
    localparam [1:0] K_PROG   = 2'h1;
    localparam [1:0] K_ERASE  = 2'h2;

    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    wire       rst_n;
    wire [4:0] pins;
    pin_sync #(.W(1), .RST_VAL(1'b0)) u_rst (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_d     (1'b1),
        .o_q     (rst_n)
    );
    pin_sync #(.W(5), .RST_VAL(5'h1d)) u_pins (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .i_d     ({i_cs_n, i_hold_n, i_wp_n, i_sclk, i_serial_in_lane0}),
        .o_q     (pins)
    );
    wire cs_s   = pins[4];
    wire hold_s = pins[3];
    wire wp_s   = pins[2];
    wire sck_s  = pins[1];
    wire si_s   = pins[0];

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg         sck_q, cs_q, hold_r;
    reg  [2:0]  bit_r, bcnt_r;
    reg  [7:0]  sh_r, op_r, out_r;
    reg         ign_r, dual_r, out_act_r, ld_r;
    reg  [16:0] addr_r, rd_ptr;
    reg  [7:0]  pofs_r;
    reg  [255:0] pval_r;
    reg         latch_r, lock_r, busy_r, ds_r, nlock_r;
    reg  [1:0]  bp_r, nbp_r, kind_r;
    reg  [16:0] wk_r;
    reg  [17:0] wk_left;
    reg  [31:0] tm_r;
    reg  [7:0]  mem  [0:(1<<ADDR_W)-1];
    reg  [7:0]  pbuf [0:`PAGE_BYTES-1];

    integer i;
    initial begin
        for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
            mem[i] = 8'hff;
        end
    end

    // ----------------------------------------
    // link decode
    // ----------------------------------------
    wire       live   = ~cs_s & ~hold_r;
    wire       rise   = live & sck_s & ~sck_q;
    wire       fall   = live & ~sck_s & sck_q;
    wire [2:0] bit_n  = dual_r ? bit_r + 3'h2 : bit_r + 3'h1;
    wire       b_done = rise & (bit_n == 3'h0);
    wire [7:0] b_in   = {sh_r[6:0], si_s};
    wire [2:0] bc_n   = (bcnt_r == 3'h6) ? bcnt_r : bcnt_r + 3'h1;
    wire [7:0] op_n   = (bcnt_r == 3'h0) ? b_in : op_r;
    // sleep or busy blocks all but the allowed codes
    wire       ign_n  = (bcnt_r != 3'h0) ? ign_r
                        : (ds_r & b_in != `CMD_WAKE)
                          | (busy_r & b_in != `CMD_STATUS_READ);
    wire       cs_up  = cs_s & ~cs_q;
    // whole bytes only, and not abandoned by a pause
    wire       exec   = cs_up & ~hold_r & ~ign_r & ~dual_r
                        & (bit_r == 3'h0) & ~busy_r;
    wire [7:0] stat   = {lock_r, 3'h0, bp_r, latch_r, busy_r};

    function prot;
        input [1:0]  lvl;
        input [16:0] a;
        input        whole;
        begin
            prot = (lvl != `PL_NONE)
                   & (whole | lvl != `PL_BLOCK1 | a[16]);
        end
    endfunction

    reg  data_ph;
    always @* begin
        case (op_n)
            `CMD_STATUS_READ, `CMD_READ_ID: data_ph = 1'b1;
            `CMD_READ, `CMD_DUAL_READ,
            `CMD_WAKE, `CMD_READ_MFR_DEV: data_ph = (bc_n >= 3'h4);
            `CMD_FAST_READ: data_ph = (bc_n >= 3'h5);
            default: data_ph = 1'b0;
        endcase
    end

    reg [7:0] ld_byte;
    always @* begin
        case (op_r)
            `CMD_STATUS_READ: ld_byte = stat;
            `CMD_READ_ID: begin
                if (rd_ptr[1:0] == 2'h0) ld_byte = MFR_ID;
                else if (rd_ptr[1:0] == 2'h1) ld_byte = DEV_ID[15:8];
                else ld_byte = DEV_ID[7:0];
            end
            `CMD_WAKE: ld_byte = SIG_ID;
            `CMD_READ_MFR_DEV: ld_byte = rd_ptr[0] ? DEV_ID[7:0] : MFR_ID;
            default: ld_byte = mem[rd_ptr];
        endcase
    end

    // ----------------------------------------
    // link side: shift, count, output
    // ----------------------------------------
    always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
            hold_r <= 1'b0;
            bit_r <= 3'h0;
            bcnt_r <= 3'h0;
            sh_r <= 8'h00;
            op_r <= 8'h00;
            out_r <= 8'h00;
            ign_r <= 1'b0;
            dual_r <= 1'b0;
            out_act_r <= 1'b0;
            ld_r <= 1'b0;
            addr_r <= 17'h00000;
            rd_ptr <= 17'h00000;
            pofs_r <= 8'h00;
            o_serial_in_lane0 <= 1'b0;
            o_serial_in_lane0_oe <= 1'b0;
            o_serial_out_lane1 <= 1'b0;
            o_serial_out_lane1_oe <= 1'b0;
        end else begin
            sck_q <= sck_s;
            cs_q <= cs_s;
            ld_r <= 1'b0;
            if (cs_s) begin
                // deselect drops the command and any pause
                hold_r <= 1'b0;
                bit_r <= 3'h0;
                bcnt_r <= 3'h0;
                ign_r <= 1'b0;
                dual_r <= 1'b0;
                out_act_r <= 1'b0;
            end else if (!hold_r && !hold_s && !sck_s) begin
                hold_r <= 1'b1;
            end else if (hold_r && hold_s && !sck_s) begin
                hold_r <= 1'b0;
            end
            if (rise) begin
                bit_r <= bit_n;
                sh_r <= b_in;
            end
            if (b_done) begin
                bcnt_r <= bc_n;
                if (bcnt_r == 3'h0) begin
                    op_r <= b_in;
                    rd_ptr <= 17'h00000;
                    ign_r <= ign_n;
                end
                if (bcnt_r >= 3'h1 && bcnt_r <= 3'h3) begin
                    addr_r <= {addr_r[8:0], b_in};
                end
                if (bcnt_r == 3'h3) begin
                    pofs_r <= b_in;
                    if (op_r != `CMD_READ_ID) begin
                        rd_ptr <= {addr_r[8:0], b_in};
                    end
                    dual_r <= (op_r == `CMD_DUAL_READ) & ~ign_r;
                end
                if (bcnt_r >= 3'h4 && op_r == `CMD_PAGE_PROGRAM) begin
                    pofs_r <= pofs_r + 8'h01;
                end
                if (data_ph && !ign_n) begin
                    ld_r <= 1'b1;
                end
            end
            if (ld_r) begin
                out_r <= ld_byte;
                out_act_r <= 1'b1;
                if (op_r == `CMD_READ_ID && rd_ptr[1:0] == 2'h2) begin
                    rd_ptr <= 17'h00000;
                end else begin
                    rd_ptr <= rd_ptr + 17'h00001;
                end
            end else if (fall && out_act_r) begin
                if (dual_r) begin
                    o_serial_out_lane1 <= out_r[7];
                    o_serial_in_lane0 <= out_r[6];
                    out_r <= {out_r[5:0], 2'h0};
                end else begin
                    o_serial_out_lane1 <= out_r[7];
                    out_r <= {out_r[6:0], 1'b0};
                end
            end
            // outputs float while paused or deselected
            o_serial_out_lane1_oe <= live & out_act_r & ~cs_up;
            o_serial_in_lane0_oe <= live & out_act_r & dual_r & ~cs_up;
        end
    end

    // ----------------------------------------
    // page buffer valid map
    // ----------------------------------------
    wire pb_we = b_done & ~ign_r & (bcnt_r >= 3'h4)
                 & (op_r == `CMD_PAGE_PROGRAM);
    always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            pval_r <= {256{1'b0}};
        end else if (b_done && bcnt_r == 3'h0) begin
            pval_r <= {256{1'b0}};
        end else if (pb_we) begin
            pval_r[pofs_r] <= 1'b1;
        end
    end

    // ----------------------------------------
    // array and page buffer writes
    // ----------------------------------------
    wire       erasing = (kind_r == K_ERASE);
    wire       wk_we   = busy_r & (wk_left != 18'h0)
                         & (erasing | (kind_r == K_PROG & pval_r[wk_r[7:0]]));
    // programming only clears bits, so unerased bytes end mixed
    wire [7:0] wk_data = erasing ? 8'hff : (mem[wk_r] & pbuf[wk_r[7:0]]);
    always @(posedge i_clock) begin
        if (pb_we) begin
            pbuf[pofs_r] <= b_in;
        end
        if (wk_we) begin
            mem[wk_r] <= wk_data;
        end
    end

    // ----------------------------------------
    // status, latch and internal operations
    // ----------------------------------------
    wire [16:0] a   = addr_r;
    wire        ok  = latch_r;
    wire        one = (bcnt_r == 3'h1);
    wire        adr = (bcnt_r == 3'h4);
    always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= 1'b0;
            bp_r <= `RST_BP;
            lock_r <= `RST_LOCK;
            nbp_r <= `RST_BP;
            nlock_r <= `RST_LOCK;
            busy_r <= 1'b0;
            ds_r <= 1'b0;
            kind_r <= K_STATUS;
            wk_r <= 17'h00000;
            wk_left <= 18'h00000;
            tm_r <= 32'h0;
        end else if (busy_r) begin
            // runs on through any pause
            if (wk_left != 18'h0) begin
                wk_r <= wk_r + 17'h00001;
                wk_left <= wk_left - 18'h00001;
            end
            if (tm_r != 32'h0) begin
                tm_r <= tm_r - 32'h1;
            end else if (wk_left == 18'h0) begin
                busy_r <= 1'b0;
                latch_r <= 1'b0;
                if (kind_r == K_STATUS) begin
                    bp_r <= nbp_r;
                    lock_r <= nlock_r;
                end
            end
        end else if (exec) begin
            case (op_r)
                `CMD_WRITE_ENABLE: if (one) latch_r <= 1'b1;
                `CMD_WRITE_DISABLE: if (one) latch_r <= 1'b0;
                `CMD_SLEEP: if (one) ds_r <= 1'b1;
                `CMD_WAKE: ds_r <= 1'b0;
                `CMD_STATUS_WRITE: begin
                    if (bcnt_r == 3'h2 && ok && wp_s) begin
                        nbp_r <= {a[`ST_BP_HI], a[`ST_BP_LO]};
                        nlock_r <= a[`ST_LOCK];
                        kind_r <= K_STATUS;
                        busy_r <= 1'b1;
                        tm_r <= STW_CYC - 1;
                    end
                end
                `CMD_PAGE_PROGRAM: begin
                    if (bcnt_r >= 3'h5 && ok && !prot(bp_r, a, 1'b0)) begin
                        kind_r <= K_PROG;
                        busy_r <= 1'b1;
                        wk_r <= {a[16:8], 8'h00};
                        wk_left <= `PAGE_BYTES;
                        tm_r <= PROG_CYC - 1;
                    end
                end
                `CMD_SMALL_WIPE: begin
                    if (adr && ok && !prot(bp_r, a, 1'b0)) begin
                        kind_r <= K_ERASE;
                        busy_r <= 1'b1;
                        wk_r <= {a[16:12], 12'h000};
                        wk_left <= `SECT_BYTES;
                        tm_r <= SECT_CYC - 1;
                    end
                end
                `CMD_LARGE_WIPE_A, `CMD_LARGE_WIPE_B: begin
                    if (adr && ok && !prot(bp_r, a, 1'b0)) begin
                        kind_r <= K_ERASE;
                        busy_r <= 1'b1;
                        wk_r <= {a[16], 16'h0000};
                        wk_left <= `BLOCK_BYTES;
                        tm_r <= BLK_CYC - 1;
                    end
                end
                `CMD_FULL_WIPE_A, `CMD_FULL_WIPE_B: begin
                    if (one && ok && !prot(bp_r, a, 1'b1)) begin
                        kind_r <= K_ERASE;
                        busy_r <= 1'b1;
                        wk_r <= 17'h00000;
                        wk_left <= `CHIP_BYTES;
                        tm_r <= CE_CYC - 1;
                    end
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // registered status outputs
    // ----------------------------------------
    always @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_operation_in_progress <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_protect_level <= `RST_BP;
            o_status_lock_bit <= `RST_LOCK;
            o_deep_sleep_mode <= 1'b0;
            o_standby <= 1'b1;
        end else begin
            o_operation_in_progress <= busy_r;
            o_write_enable_latch <= latch_r;
            o_protect_level <= bp_r;
            o_status_lock_bit <= lock_r;
            o_deep_sleep_mode <= ds_r;
            o_standby <= cs_s & ~busy_r;
        end
    end
endmodule

`default_nettype wire

// >>> hw/pin_sync.v
// two-flop synchroniser, any width
// assumes an async active-low reset; o_q is the only output read
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter       W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         i_clock,
    input  wire         i_rst_n,
    input  wire [W-1:0] i_d,
    output reg  [W-1:0] o_q
);
    reg [W-1:0] meta_r;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= RST_VAL;
            o_q    <= RST_VAL;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule

`default_nettype wire

// >>> shared/flash_guard_defines.vh
// constants for the serial flash command and write protection logic
// assumes the includer runs on one system clock of CLK_MHZ megahertz
`ifndef FLASH_GUARD_DEFINES_VH
`define FLASH_GUARD_DEFINES_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_WRITE_ENABLE  8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_ID       8'h9f
`define CMD_STATUS_READ   8'h05
`define CMD_STATUS_WRITE  8'h01
`define CMD_READ          8'h03
`define CMD_FAST_READ     8'h0b
`define CMD_DUAL_READ     8'h3b
`define CMD_SMALL_WIPE    8'h20
`define CMD_LARGE_WIPE_A  8'h52
`define CMD_LARGE_WIPE_B  8'hd8
`define CMD_FULL_WIPE_A   8'h60
`define CMD_FULL_WIPE_B   8'hc7
`define CMD_PAGE_PROGRAM  8'h02
`define CMD_SLEEP         8'hb9
`define CMD_WAKE          8'hab
`define CMD_READ_MFR_DEV  8'h90

// ----------------------------------------
// status byte layout and reset values
// ----------------------------------------
`define ST_BP_LO    2
`define ST_BP_HI    3
`define ST_LOCK     7
`define RST_BP      2'h0
`define RST_LOCK    1'b0
`define PL_NONE     2'h0
`define PL_BLOCK1   2'h1

// ----------------------------------------
// geometry
// ----------------------------------------
`define ADDR_W      17
`define PAGE_BYTES  18'h00100
`define SECT_BYTES  18'h01000
`define BLOCK_BYTES 18'h10000
`define CHIP_BYTES  18'h20000

// ----------------------------------------
// timing, in microseconds, and derived cycle counts
// ----------------------------------------
`define CLK_MHZ       25
`define PROG_MAX_US   3000
`define SECT_TYP_US   40000
`define BLK_US        500000
`define CE_MAX_US     2000000
`define STW_US        10000
`define PROG_CYC      (`PROG_MAX_US * `CLK_MHZ)
`define SECT_CYC      (`SECT_TYP_US * `CLK_MHZ)
`define BLK_CYC       (`BLK_US * `CLK_MHZ)
`define CE_CYC        (`CE_MAX_US * `CLK_MHZ)
`define STW_CYC       (`STW_US * `CLK_MHZ)

`endif
